// File: common/fpt_pkg.sv
// Contract
// - four independent fan power and tach channels
// - per-fan duty zero to full on switch
// - power waveform runs at eighteen hertz
// - tach averaged over one eighth second window
// - fans measured in rotation, half second refresh
// - reported fan forced fully on at window start
// - force holds until glitch delay and two edges
// - stretched pulse never longer than one eighth second
// - speed derived from frequency and pulses per revolution
// - fail-safe forces full power after host silence
// - power-up loads full power or boot value
// - fans started one by one, half second after each nonzero-duty fan
// - report: index, cycles, ticks high then low
package fpt_pkg;
    localparam int         NFAN          = 4;
    localparam int         CLK_HZ        = 10_000_000;
    localparam int         PWM_HZ        = 18;
    localparam int         PWM_STEPS     = 100;
    localparam int         PWM_STEP_CYC  = CLK_HZ / (PWM_HZ * PWM_STEPS);
    localparam logic [6:0] DUTY_FULL     = 7'h64;
    localparam int         TICK_NS       = 4000;
    localparam int         TICK_CYC      = TICK_NS / (1_000_000_000 / CLK_HZ);
    localparam int         WINDOW_MS     = 125;
    localparam int         WINDOW_TICKS  = WINDOW_MS * (1_000_000 / TICK_NS);
    localparam int         STAGGER_MS    = 500;
    localparam int         STAGGER_TICKS = STAGGER_MS * (1_000_000 / TICK_NS);
    localparam int         RPM_NUM       = 60 * (1_000_000_000 / TICK_NS);

    typedef enum logic [1:0] {
        FPT_DV_IDLE = 2'b01,
        FPT_DV_RUN  = 2'b10
    } fpt_div_state_t;

    function automatic logic [6:0] fpt_clamp(input logic [6:0] v);
        return (v > DUTY_FULL) ? DUTY_FULL : v;
    endfunction : fpt_clamp

    function automatic logic [6:0] fpt_eff(input logic [6:0] duty, input logic trip, input logic en);
        return (trip && en) ? DUTY_FULL : duty;
    endfunction : fpt_eff
endpackage : fpt_pkg

// File: common/fpt_meas_if.sv
`timescale 1ns/1ps
interface fpt_meas_if;
    logic        tick;
    logic        win_end;
    logic [1:0]  sel;
    logic [7:0]  ppr;
    logic        tach_edge;
    logic        res_valid;
    logic [1:0]  res_fan;
    logic [7:0]  res_cycles;
    logic [15:0] res_ticks;
    logic [31:0] res_rpm;
    modport ctrl (output win_end, sel, ppr,
                  input  tick, tach_edge, res_valid, res_fan, res_cycles, res_ticks, res_rpm);
    modport meas (input  win_end, sel, ppr,
                  output tick, tach_edge, res_valid, res_fan, res_cycles, res_ticks, res_rpm);
endinterface : fpt_meas_if

// File: design/fpt_tach_meas.sv
`timescale 1ns/1ps
module fpt_tach_meas (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic [3:0] tach_in,
    fpt_meas_if.meas        m
);
    import fpt_pkg::*;

    logic [3:0]     s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [5:0]     tdiv_reg;
    logic [15:0]    time_reg, first_reg, last_reg, rem_sub;
    logic [7:0]     edges_reg;
    logic           rise;
    fpt_div_state_t st_reg;
    logic [4:0]     cnt_reg;
    logic [23:0]    den_reg, rem_reg;
    logic [31:0]    quo_reg;
    logic [24:0]    trial;
    logic [7:0]     cyc;
    logic [15:0]    tks;
    logic [7:0]     edges_fin;
    logic [15:0]    first_fin, last_fin;

    // ****************************************
    // tach synchronisers and tick base
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            // tach idles high through its pull-up, so no false edge after reset
            s1_reg  <= 4'hf;
            s2_reg  <= 4'hf;
            s3_reg  <= 4'hf;
            lvl_reg <= 4'hf;
        end else begin
            s1_reg <= tach_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < NFAN; i++) begin
                if (s2_reg[i] == s3_reg[i]) lvl_reg[i] <= s3_reg[i];
            end
        end
    end

    assign rise = (s2_reg[m.sel] == s3_reg[m.sel]) && s3_reg[m.sel] && !lvl_reg[m.sel];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tdiv_reg <= 6'h00;
            m.tick   <= 1'b0;
        end else begin
            m.tick   <= (tdiv_reg == 6'(TICK_CYC - 1));
            tdiv_reg <= (tdiv_reg == 6'(TICK_CYC - 1)) ? 6'h00 : tdiv_reg + 6'h01;
        end
    end

    // ****************************************
    // edge capture in the window
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            time_reg    <= 16'h0000;
            first_reg   <= 16'h0000;
            last_reg    <= 16'h0000;
            edges_reg   <= 8'h00;
            m.tach_edge <= 1'b0;
        end else if (m.win_end) begin
            time_reg    <= 16'h0000;
            edges_reg   <= 8'h00;
            m.tach_edge <= 1'b0;
        end else begin
            m.tach_edge <= rise;
            if (m.tick && time_reg != 16'hffff) time_reg <= time_reg + 16'h0001;
            if (rise) begin
                if (edges_reg == 8'h00) first_reg <= time_reg;
                last_reg <= time_reg;
                if (edges_reg != 8'hff) edges_reg <= edges_reg + 8'h01;
            end
        end
    end

    // ****************************************
    // rpm divider
    // ****************************************
    // a rise in the window-end cycle still belongs to the closing window
    assign edges_fin = (rise && edges_reg != 8'hff) ? edges_reg + 8'h01 : edges_reg;
    assign first_fin = (rise && edges_reg == 8'h00) ? time_reg : first_reg;
    assign last_fin  = rise ? time_reg : last_reg;
    assign cyc     = (edges_fin >= 8'h02) ? edges_fin - 8'h01 : 8'h00;
    assign rem_sub = last_fin - first_fin;
    assign tks     = (edges_fin >= 8'h02) ? rem_sub : 16'h0000;
    assign trial   = {rem_reg, quo_reg[31]};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_reg       <= FPT_DV_IDLE;
            cnt_reg      <= 5'h00;
            den_reg      <= 24'h000000;
            rem_reg      <= 24'h000000;
            quo_reg      <= 32'h00000000;
            m.res_valid  <= 1'b0;
            m.res_fan    <= 2'h0;
            m.res_cycles <= 8'h00;
            m.res_ticks  <= 16'h0000;
            m.res_rpm    <= 32'h00000000;
        end else begin
            m.res_valid <= 1'b0;
            unique case (st_reg)
                FPT_DV_IDLE: begin
                    if (m.win_end) begin
                        m.res_fan    <= m.sel;
                        m.res_cycles <= cyc;
                        m.res_ticks  <= tks;
                        den_reg      <= 24'(tks) * 24'(m.ppr);
                        quo_reg      <= 32'(cyc) * 32'(RPM_NUM);
                        rem_reg      <= 24'h000000;
                        cnt_reg      <= 5'h00;
                        if (cyc == 8'h00 || tks == 16'h0000 || m.ppr == 8'h00) begin
                            m.res_rpm   <= 32'h00000000;
                            m.res_valid <= 1'b1;
                        end else begin
                            st_reg <= FPT_DV_RUN;
                        end
                    end
                end
                FPT_DV_RUN: begin
                    if (trial >= {1'b0, den_reg}) begin
                        rem_reg <= 24'(trial - {1'b0, den_reg});
                        quo_reg <= {quo_reg[30:0], 1'b1};
                    end else begin
                        rem_reg <= trial[23:0];
                        quo_reg <= {quo_reg[30:0], 1'b0};
                    end
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == 5'h1f) begin
                        m.res_rpm   <= {quo_reg[30:0], (trial >= {1'b0, den_reg})};
                        m.res_valid <= 1'b1;
                        st_reg      <= FPT_DV_IDLE;
                    end
                end
                default: st_reg <= FPT_DV_IDLE;
            endcase
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    rpm_done_a: assert property (m.win_end && st_reg == FPT_DV_IDLE |-> ##[1:40] m.res_valid)
        else $error("rpm result not produced in time");
    sync_edge_a: assert property (m.tach_edge |-> $past(s3_reg[m.sel]) == 1'b1)
        else $error("tach edge without synchronised high level");
endmodule : fpt_tach_meas

// File: design/fpt_top.sv
`timescale 1ns/1ps
module fpt_top
    import fpt_pkg::*;
#(
    parameter int PWM_STEP_CYC_P  = fpt_pkg::PWM_STEP_CYC,
    parameter int WINDOW_TICKS_P  = fpt_pkg::WINDOW_TICKS,
    parameter int STAGGER_TICKS_P = fpt_pkg::STAGGER_TICKS
) (
    input  wire logic            clock,
    input  wire logic            reset_n,
    input  wire logic [3:0]      tach_in,
    input  wire logic            power_wr,
    input  wire logic [1:0]      power_wr_fan,
    input  wire logic [6:0]      power_wr_value,
    input  wire logic [3:0]      report_en,
    input  wire logic [3:0]      failsafe_en,
    input  wire logic [7:0]      failsafe_interval,
    input  wire logic [15:0]     glitch_delay,
    input  wire logic [7:0]      ppr,
    input  wire logic            boot_valid,
    input  wire logic [3:0][6:0] boot_power,
    output logic      [3:0]      fan_on,
    output logic      [3:0]      failsafe_active,
    output logic                 rpm_valid,
    output logic      [1:0]      rpm_fan,
    output logic      [31:0]     rpm_value,
    output logic      [7:0]      report_byte,
    output logic                 report_strobe,
    output logic                 report_first
);
    fpt_meas_if m_if();

    fpt_tach_meas u_meas (
        .clock   (clock),
        .reset_n (reset_n),
        .tach_in (tach_in),
        .m       (m_if.meas)
    );

    logic            init_done_reg;
    logic [3:0][6:0] duty_reg;
    logic [3:0][7:0] fs_cnt_reg;
    logic [3:0]      fs_trip_reg;
    logic [15:0]     sdiv_reg, win_cnt_reg, glit_cnt_reg;
    logic [6:0]      step_reg;
    logic            step_en, win_end_reg, force_reg;
    logic [1:0]      sel_reg, edge_cnt_reg;
    logic [3:0]      pwm_on, started_reg;
    logic [2:0]      stg_idx_reg, rep_left_reg;
    logic [16:0]     stg_cnt_reg;
    logic [31:0]     rep_sh_reg;

    assign m_if.win_end = win_end_reg;
    assign m_if.sel     = sel_reg;
    assign m_if.ppr     = ppr;

    // ****************************************
    // power settings and fail-safe
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            init_done_reg <= 1'b0;
            duty_reg      <= '0;
        end else begin
            init_done_reg <= 1'b1;
            if (!init_done_reg) begin
                for (int i = 0; i < NFAN; i++) begin
                    duty_reg[i] <= boot_valid ? fpt_clamp(boot_power[i]) : DUTY_FULL;
                end
            end else if (power_wr) begin
                duty_reg[power_wr_fan] <= fpt_clamp(power_wr_value);
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fs_cnt_reg      <= '0;
            fs_trip_reg     <= 4'h0;
            failsafe_active <= 4'h0;
        end else begin
            for (int i = 0; i < NFAN; i++) begin
                if (power_wr && power_wr_fan == 2'(i)) begin
                    fs_cnt_reg[i]  <= 8'h00;
                    fs_trip_reg[i] <= 1'b0;
                end else if (!failsafe_en[i]) begin
                    fs_cnt_reg[i]  <= 8'h00;
                    fs_trip_reg[i] <= 1'b0;
                end else if (win_end_reg && !fs_trip_reg[i]) begin
                    if (fs_cnt_reg[i] == failsafe_interval) fs_trip_reg[i] <= 1'b1;
                    else fs_cnt_reg[i] <= fs_cnt_reg[i] + 8'h01;
                end
            end
            failsafe_active <= fs_trip_reg & failsafe_en;
        end
    end

    // ****************************************
    // pwm at the switching rate
    // ****************************************
    assign step_en = (sdiv_reg == 16'(PWM_STEP_CYC_P - 1));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sdiv_reg <= 16'h0000;
            step_reg <= 7'h00;
        end else begin
            sdiv_reg <= step_en ? 16'h0000 : sdiv_reg + 16'h0001;
            if (step_en) step_reg <= (step_reg == 7'(PWM_STEPS - 1)) ? 7'h00 : step_reg + 7'h01;
        end
    end

    always_comb begin
        for (int i = 0; i < NFAN; i++) begin
            pwm_on[i] = step_reg < fpt_eff(duty_reg[i], fs_trip_reg[i], failsafe_en[i]);
        end
    end

    // ****************************************
    // measurement rotation and on-time stretch
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            win_cnt_reg <= 16'h0000;
            win_end_reg <= 1'b0;
            sel_reg     <= 2'h0;
        end else begin
            win_end_reg <= 1'b0;
            if (m_if.tick) begin
                if (win_cnt_reg == 16'(WINDOW_TICKS_P - 1)) begin
                    win_cnt_reg <= 16'h0000;
                    win_end_reg <= 1'b1;
                end else begin
                    win_cnt_reg <= win_cnt_reg + 16'h0001;
                end
            end
            if (win_end_reg) sel_reg <= sel_reg + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            force_reg    <= 1'b0;
            glit_cnt_reg <= 16'h0000;
            edge_cnt_reg <= 2'h0;
        end else if (win_end_reg) begin
            force_reg    <= report_en[sel_reg + 2'h1];
            glit_cnt_reg <= 16'h0000;
            edge_cnt_reg <= 2'h0;
        end else begin
            if (m_if.tick && glit_cnt_reg != 16'hffff) glit_cnt_reg <= glit_cnt_reg + 16'h0001;
            if (m_if.tach_edge && edge_cnt_reg != 2'h2) edge_cnt_reg <= edge_cnt_reg + 2'h1;
            if (glit_cnt_reg >= glitch_delay && edge_cnt_reg == 2'h2) force_reg <= 1'b0;
        end
    end

    // ****************************************
    // staggered start
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            started_reg <= 4'h0;
            stg_idx_reg <= 3'h0;
            stg_cnt_reg <= 17'h00000;
        end else if (init_done_reg) begin
            if (stg_cnt_reg != 17'h00000) begin
                if (m_if.tick) stg_cnt_reg <= stg_cnt_reg - 17'h00001;
            end else if (stg_idx_reg < 3'h4) begin
                started_reg[stg_idx_reg[1:0]] <= 1'b1;
                stg_idx_reg <= stg_idx_reg + 3'h1;
                if (duty_reg[stg_idx_reg[1:0]] != 7'h00) stg_cnt_reg <= 17'(STAGGER_TICKS_P);
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fan_on <= 4'h0;
        end else begin
            for (int i = 0; i < NFAN; i++) begin
                fan_on[i] <= started_reg[i] && (pwm_on[i] || (force_reg && sel_reg == 2'(i)));
            end
        end
    end

    // ****************************************
    // speed results and report bytes
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rpm_valid <= 1'b0;
            rpm_fan   <= 2'h0;
            rpm_value <= 32'h00000000;
        end else begin
            rpm_valid <= m_if.res_valid;
            if (m_if.res_valid) begin
                rpm_fan   <= m_if.res_fan;
                rpm_value <= m_if.res_rpm;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rep_sh_reg    <= 32'h00000000;
            rep_left_reg  <= 3'h0;
            report_byte   <= 8'h00;
            report_strobe <= 1'b0;
            report_first  <= 1'b0;
        end else if (rep_left_reg != 3'h0) begin
            report_byte   <= rep_sh_reg[31:24];
            report_strobe <= 1'b1;
            report_first  <= (rep_left_reg == 3'h4);
            rep_sh_reg    <= {rep_sh_reg[23:0], 8'h00};
            rep_left_reg  <= rep_left_reg - 3'h1;
        end else begin
            report_strobe <= 1'b0;
            report_first  <= 1'b0;
            if (m_if.res_valid && report_en[m_if.res_fan]) begin
                rep_sh_reg   <= {6'h00, m_if.res_fan, m_if.res_cycles, m_if.res_ticks};
                rep_left_reg <= 3'h4;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    pwm_full_on_a: assert property (started_reg[0] && !power_wr &&
        fpt_eff(duty_reg[0], fs_trip_reg[0], failsafe_en[0]) == DUTY_FULL |=> fan_on[0])
        else $error("full duty fan not on");
    pwm_zero_off_a: assert property (started_reg[0] && duty_reg[0] == 7'h00 && !failsafe_en[0] &&
        !(force_reg && sel_reg == 2'h0) |=> !fan_on[0])
        else $error("zero duty fan switched on");
    step_wrap_a: assert property (step_en && step_reg == 7'h63 |=> step_reg == 7'h00 ##1 step_reg == 7'h00)
        else $error("pwm step wrap wrong");
    win_len_a: assert property (win_end_reg |-> $past(m_if.tick) && win_cnt_reg == 16'h0000)
        else $error("window end off the tick boundary");
    rotate_a: assert property (win_end_reg |=> sel_reg == $past(sel_reg) + 2'h1)
        else $error("measurement rotation skipped");
    force_start_a: assert property (win_end_reg && report_en[sel_reg + 2'h1] |=> force_reg)
        else $error("reported fan not forced at window start");
    force_hold_a: assert property (force_reg && !win_end_reg && edge_cnt_reg != 2'h2 |=> force_reg)
        else $error("force released before two edges");
    force_stop_a: assert property (win_end_reg && !report_en[sel_reg + 2'h1] |=> !force_reg)
        else $error("stretch ran past the window");
    failsafe_a: assert property (fs_trip_reg[2] && failsafe_en[2] && started_reg[2] && !power_wr
        |=> fan_on[2] ##1 failsafe_active[2])
        else $error("fail-safe fan not at full power");
    wr_restart_a: assert property (power_wr && power_wr_fan == 2'h2 |=> fs_cnt_reg[2] == 8'h00 && !fs_trip_reg[2])
        else $error("power write did not restart fail-safe");
    boot_load_a: assert property (!init_done_reg && !boot_valid |=> duty_reg[0] == DUTY_FULL)
        else $error("default power not loaded");
    stagger_a: assert property ($countones(started_reg ^ $past(started_reg)) <= 1)
        else $error("two fans started together");
    report_seq_a: assert property (report_first |-> report_strobe ##1 report_strobe [*3] ##1 !report_strobe)
        else $error("report not four bytes");

    force_release_c: cover property (force_reg ##1 !force_reg && !win_end_reg);
    failsafe_trip_c: cover property ($rose(failsafe_active[2]));
    report_sent_c:   cover property (report_first);
    all_started_c:   cover property (started_reg == 4'hf);
endmodule : fpt_top

// File: dv/fpt_fan_model.sv
`timescale 1ns/1ps
module fpt_fan_model (
    input  wire logic             clock,
    input  wire logic [3:0]       fan_on,
    input  wire logic [3:0][11:0] tach_period,
    output logic      [3:0]       tach_in
);
    int unsigned spin [4] = '{default: 0};

    // ****************************************
    // rotor phase advances only while powered
    // ****************************************
    always @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (fan_on[i] === 1'b1) begin
                spin[i] <= (spin[i] + 1) % tach_period[i];
            end
        end
    end

    // unpowered tach output floats to its pull-up level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            tach_in[i] = (fan_on[i] !== 1'b1) ? 1'b1 : (spin[i] >= tach_period[i] / 2);
        end
    end
endmodule : fpt_fan_model

// File: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb_top;
    import fpt_pkg::*;
    localparam int    WCYC    = 2000;
    localparam int    PCYC    = 400;
    localparam int    PTAB[4] = '{80, 200, 400, 1000};
    logic             clock, reset_n, power_wr, boot_valid, rpm_valid, report_strobe, report_first;
    logic [1:0]       power_wr_fan, rpm_fan;
    logic [6:0]       power_wr_value;
    logic [3:0]       tach_in, report_en, failsafe_en, fan_on, failsafe_active;
    logic [7:0]       failsafe_interval, ppr, report_byte;
    logic [15:0]      glitch_delay;
    logic [31:0]      rpm_value;
    logic [3:0][6:0]  boot_power;
    logic [3:0][11:0] tach_period;
    logic [33:0]      rq[$];
    logic [8:0]       bq[$];
    int               fails, cmp_count, strobes, rpms, t, w, on_cnt[4], per[4], dv[4];
    longint           last, c, k;

    fpt_top #(.PWM_STEP_CYC_P(4), .WINDOW_TICKS_P(50), .STAGGER_TICKS_P(20)) uut (
        .clock(clock), .reset_n(reset_n), .tach_in(tach_in), .power_wr(power_wr),
        .power_wr_fan(power_wr_fan), .power_wr_value(power_wr_value), .report_en(report_en),
        .failsafe_en(failsafe_en), .failsafe_interval(failsafe_interval), .glitch_delay(glitch_delay),
        .ppr(ppr), .boot_valid(boot_valid), .boot_power(boot_power), .fan_on(fan_on),
        .failsafe_active(failsafe_active), .rpm_valid(rpm_valid), .rpm_fan(rpm_fan), .rpm_value(rpm_value),
        .report_byte(report_byte), .report_strobe(report_strobe), .report_first(report_first));
    fpt_fan_model fan (.clock(clock), .fan_on(fan_on), .tach_period(tach_period), .tach_in(tach_in));

    // ****************************************
    // helpers
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic wr(input logic [1:0] f, input logic [6:0] v);
        power_wr = 1'b1;
        power_wr_fan = f;
        power_wr_value = v;
        cyc(1);
        power_wr = 1'b0;
        cyc(3);
    endtask : wr
    task automatic count_on();
        on_cnt = '{default: 0};
        repeat (PCYC) begin
            cyc(1);
            foreach (on_cnt[i]) on_cnt[i] += int'(fan_on[i] === 1'b1);
        end
    endtask : count_on
    task automatic wait_rise(input int f, input int lim);
        for (t = 0; fan_on[f] !== 1'b1 && t < lim; t++) cyc(1);
    endtask : wait_rise
    task automatic wait_fan(input logic [1:0] f);
        for (t = 0; !(rpm_valid === 1'b1 && rpm_fan === f) && t < 5 * WCYC; t++) cyc(1);
        cyc(10);
    endtask : wait_fan
    task automatic pulse(input logic [15:0] g);
        glitch_delay = g;
        wait_rise(1, 9 * WCYC);
        for (w = 0; fan_on[1] === 1'b1 && w < 3 * WCYC; w++) cyc(1);
    endtask : pulse
    task automatic end_of_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin : watchdog
        cyc(99_000);
        fails++;
        end_of_test();
    end
    initial begin : watch
        logic [33:0] n;
        logic [8:0]  b;
        forever begin
            @(posedge clock);
            #1;
            strobes += int'(report_strobe === 1'b1);
            if (rpm_valid === 1'b1) begin
                rpms++;
                if (rq.size() > 0) begin
                    n = rq.pop_front();
                    `CHK(($time - last) / 100 inside {[WCYC - 34 : WCYC + 34]}, 1'b1)
                    `CHK({rpm_fan, rpm_value}, n)
                end
                last = $time;
            end
            if (report_strobe === 1'b1 && bq.size() > 0) begin
                b = bq.pop_front();
                `CHK({report_first, report_byte}, b)
            end
        end
    end

    // ****************************************
    // stimulus
    // ****************************************
    initial begin : main
        void'($urandom(97));
        {power_wr, power_wr_fan, power_wr_value, boot_valid, boot_power, report_en, failsafe_en} = '0;
        failsafe_interval = 8'h02;
        glitch_delay = 16'h000a;
        ppr = 8'h02;
        reset_n = 1'b0;
        foreach (per[i]) begin
            per[i] = PTAB[$urandom % 4];
            tach_period[i] = 12'(per[i]);
        end
        cyc(2);
        `CHK(fan_on, 4'h0)
        reset_n = 1'b1;
        wait_rise(0, 100);
        `CHK(t < 10, 1'b1)
        wait_rise(1, WCYC);
        `CHK(t inside {[760:810]}, 1'b1)
        `CHK(fan_on[3:2], 2'b00)
        cyc(2400);
        dv = '{0, 120, 100, 20 + $urandom % 80};
        foreach (dv[i]) wr(i, 7'(dv[i]));
        cyc(PCYC);
        count_on();
        foreach (dv[i]) `CHK(on_cnt[i], (dv[i] > 100 ? 100 : dv[i]) * 4)
        foreach (dv[i]) wr(i, 7'h64);
        ppr = 8'(1 + $urandom % 4);
        report_en = 4'hf;
        wait_fan(3);
        for (int f = 0; f < 4; f++) begin
            c = WCYC / per[f] - 1;
            k = c * per[f] / 40;
            rq.push_back({2'(f), 32'(c * RPM_NUM / (k * ppr))});
            bq.push_back({1'b1, 8'(f)});
            bq.push_back({1'b0, 8'(c)});
            bq.push_back({1'b0, 8'(k >> 8)});
            bq.push_back({1'b0, 8'(k)});
        end
        wait_fan(3);
        `CHK(rq.size() + bq.size(), 0)
        report_en = 4'h0;
        wait_fan(3);
        strobes = 0;
        rpms = 0;
        cyc(4 * WCYC - 100);
        `CHK(strobes, 0)
        `CHK(rpms, 3)
        wr(1, 7'h00);
        report_en = 4'h2;
        pulse(16'h000a);
        `CHK(w inside {[400:WCYC + 2]}, 1'b1)
        pulse(16'hffff);
        `CHK(w inside {[WCYC - 3:WCYC + 2]}, 1'b1)
        report_en = 4'h0;
        failsafe_en = 4'h4;
        wr(2, 7'h14);
        cyc(3990);
        `CHK(failsafe_active, 4'h0)
        cyc(2110);
        `CHK(failsafe_active, 4'h4)
        count_on();
        `CHK(on_cnt[2], PCYC)
        repeat (5) begin
            wr(2, 7'h14);
            cyc(1500);
            `CHK(failsafe_active, 4'h0)
        end
        failsafe_en = 4'h0;
        reset_n = 1'b0;
        boot_valid = 1'b1;
        foreach (dv[i]) begin
            dv[i] = 20 + $urandom % 80;
            boot_power[i] = 7'(dv[i]);
        end
        cyc(2);
        reset_n = 1'b1;
        cyc(3300);
        count_on();
        foreach (dv[i]) `CHK(on_cnt[i], dv[i] * 4)
        end_of_test();
    end
endmodule : tb_top
